/* File: core/activity_stretcher.sv */
// Purpose: One-shot stretcher for a byte activity pulse.
// Assumes: Byte pulses are one cycle wide and synchronous to pclk.
// Notes:   Every pulse reloads the full hold time.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_pin_regs.svh"

module activity_stretcher #(
  parameter int unsigned HOLD_CYCLES = `LED_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Activity
  input  wire logic byte_pulse,
  output logic      active
);

  logic [`LED_COUNT_WIDTH-1:0] count;       // Remaining hold time
  logic [`LED_COUNT_WIDTH-1:0] next_count;
  logic                        next_active;

  // Reload on every byte so sustained traffic keeps the LED lit
  always_comb begin
    next_count = count;
    if (byte_pulse) begin
      next_count = `LED_COUNT_WIDTH'(HOLD_CYCLES);  // [RULE5] [RULE10]
    end else if (count != '0) begin
      next_count = count - `LED_COUNT_WIDTH'(1);
    end
    next_active = (next_count != '0);             // [RULE5]
  end

  // Registered so the LED drive never glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count  <= '0;
      active <= 1'b0;
    end else begin
      count  <= next_count;
      active <= next_active;
    end
  end

endmodule // activity_stretcher
`default_nettype wire

/* File: core/cfg_pin_pkg.sv */
// Purpose: Types shared by the configurable pin status block.
// Assumes: Four-bit function code per pin.
// Notes:   Codes 8 to 15 are unused and leave the pin released.
package cfg_pin_pkg;

  // Function that a configurable pin carries
  typedef enum logic [3:0] {
    FUNC_TX_LED       = 4'h0,
    FUNC_RX_LED       = 4'h1,
    FUNC_COMBINED_LED = 4'h2,
    FUNC_LINE_DRIVER  = 4'h3,
    FUNC_POWER_EN_N   = 4'h4,
    FUNC_SUSPEND_N    = 4'h5,
    FUNC_CLK_12M      = 4'h6,
    FUNC_CLK_6M       = 4'h7
  } pin_func_type;

  // Drive pair for one pin
  typedef struct packed {
    logic oe;
    logic level;
  } pin_drive_type;

endpackage

/* File: core/cfg_pin_regs.svh */
// Purpose: Offsets, field positions, reset values and timing counts for the
//          configurable pin status block.
// Assumes: APB byte addressing, 32-bit data, one register per aligned word.
// Notes:   Definitions only; included by bare name.
`ifndef CFG_PIN_REGS_SVH
`define CFG_PIN_REGS_SVH

// Register byte offsets
`define PIN_FUNC_OFFSET    8'h00
`define PIN_STATUS_OFFSET  8'h04
`define WAKE_CTRL_OFFSET   8'h08

// Field layout
`define PIN_COUNT          5
`define FUNC_WIDTH         4
`define FUNC_FIELD_WIDTH   20
`define STAT_DRIVE_LSB     0
`define STAT_OE_LSB        5
`define STAT_SUSPEND_BIT   10
`define STAT_SHIFT_BIT     11
`define STAT_TX_ACT_BIT    12
`define STAT_RX_ACT_BIT    13
`define WAKE_ENABLE_BIT    0

// Reset values: pin0 tx LED, pin1 rx LED, pin2 line driver, pin3 power, pin4 suspend
`define PIN_FUNC_RESET     20'h54310
`define WAKE_CTRL_RESET    1'b1

// Timing
`define PCLK_PERIOD_NS     25
`define LED_HOLD_NS        50000000
`define LED_HOLD_CYCLES    ((`LED_HOLD_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`define LED_COUNT_WIDTH    21

// Clock output phase steps against a modulus of ten pclk steps
`define NCO_MODULUS        4'hA
`define CLK12_STEP         4'h6
`define CLK6_STEP          4'h3

`endif

/* File: core/clock_out_gen.sv */
// Purpose: Fractional clock output derived from pclk by a phase accumulator.
// Assumes: Output rate is pclk * STEP / (2 * modulus).
// Notes:   Average rate is exact; edges carry one pclk period of jitter.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_pin_regs.svh"

module clock_out_gen #(
  parameter logic [3:0] STEP = `CLK12_STEP
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Generated clock
  output logic      clk_out
);

  logic [3:0] phase;        // Phase accumulator
  logic [3:0] next_phase;
  logic       next_clk_out;
  logic [4:0] sum;          // Unwrapped phase

  // Toggle on each wrap; 40 MHz cannot divide to 12 MHz by an integer
  always_comb begin
    sum          = {1'b0, phase} + {1'b0, STEP};
    next_phase   = phase;
    next_clk_out = clk_out;
    if (sum >= {1'b0, `NCO_MODULUS}) begin
      next_phase   = 4'(sum - {1'b0, `NCO_MODULUS});
      next_clk_out = ~clk_out;                   // [RULE8]
    end else begin
      next_phase = sum[3:0];
    end
  end

  // Registered output, free of decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase   <= 4'h0;
      clk_out <= 1'b0;
    end else begin
      phase   <= next_phase;
      clk_out <= next_clk_out;
    end
  end

endmodule // clock_out_gen
`default_nettype wire

/* File: core/config_pin_status_outputs.sv */
// Purpose: Function selection and drive for five configurable status pins.
// Assumes: UART and USB status inputs are synchronous to pclk.
// Notes:   Pin drive is registered, one pclk behind its status input and two behind a byte pulse.
//
// Contract
// RULE1: Line driver enable only while shifting character.
// RULE2: Defaults: pin2 line driver, pin3 power enable.
// RULE3: Any pin may carry any LED function.
// RULE4: LED pin released idle, low on activity.
// RULE5: One-shot timer stretches each LED indication.
// RULE6: Combined LED lights on transmit or receive.
// RULE7: Power enable low, suspend high; invert on suspend.
// RULE8: Clock output function includes 12 MHz choice.
// RULE9: Ring indicator during suspend requests host wake.
// RULE10: Each byte retriggers LED one-shot timer.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_pin_regs.svh"

module config_pin_status_outputs
  import cfg_pin_pkg::*;
#(
  parameter int unsigned LED_HOLD_CYCLES = `LED_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // UART and USB status
  input  wire logic        tx_shifting,
  input  wire logic        tx_byte,
  input  wire logic        rx_byte,
  input  wire logic        usb_suspended,
  input  wire logic        ring_indicator_n,
  output logic             remote_wakeup,
  // Configurable pins
  input  wire logic [4:0]  config_pin_in,
  output logic [4:0]       config_pin_out,
  output logic [4:0]       config_pin_oe
);

  // Register state
  logic [`FUNC_FIELD_WIDTH-1:0] pin_func;        // Function code per pin
  logic [`FUNC_FIELD_WIDTH-1:0] next_pin_func;
  logic                         wake_enable;     // Allows host wake requests
  logic                         next_wake_enable;
  logic [31:0]                  next_prdata;

  // Pin and wake state
  logic [4:0] next_pin_out;
  logic [4:0] next_pin_oe;
  logic       ring_prev;                          // Last ring level
  logic       next_remote_wakeup;

  // Status sources
  logic tx_active;       // Stretched transmit activity
  logic rx_active;       // Stretched receive activity
  logic clk_12m;         // 12 MHz average output
  logic clk_6m;          // 6 MHz average output

  // Address decode for the error path; read and write paths compare offsets directly
  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == `PIN_FUNC_OFFSET) || (addr == `PIN_STATUS_OFFSET) ||
                  (addr == `WAKE_CTRL_OFFSET);
  endfunction

  // Drive for one pin given its function code
  function automatic pin_drive_type pin_drive(input logic [3:0] code);
    pin_drive_type d;
    d = '{oe: 1'b0, level: 1'b0};
    unique case (code)
      FUNC_TX_LED:       d = '{oe: tx_active, level: 1'b0};              // [RULE3] [RULE4]
      FUNC_RX_LED:       d = '{oe: rx_active, level: 1'b0};              // [RULE3] [RULE4]
      FUNC_COMBINED_LED: d = '{oe: tx_active | rx_active, level: 1'b0};  // [RULE6]
      FUNC_LINE_DRIVER:  d = '{oe: 1'b1, level: tx_shifting};            // [RULE1]
      FUNC_POWER_EN_N:   d = '{oe: 1'b1, level: usb_suspended};          // [RULE7]
      FUNC_SUSPEND_N:    d = '{oe: 1'b1, level: ~usb_suspended};         // [RULE7]
      FUNC_CLK_12M:      d = '{oe: 1'b1, level: clk_12m};                // [RULE8]
      FUNC_CLK_6M:       d = '{oe: 1'b1, level: clk_6m};
      // Unused codes leave the pin released
      default:           d = '{oe: 1'b0, level: 1'b0};
    endcase
    pin_drive = d;
  endfunction

  // Transmit activity one-shot
  activity_stretcher #(
    .HOLD_CYCLES (LED_HOLD_CYCLES)
  ) u_tx_stretch (
    .pclk       (pclk),
    .presetn    (presetn),
    .byte_pulse (tx_byte),
    .active     (tx_active)
  );

  // Receive activity one-shot
  activity_stretcher #(
    .HOLD_CYCLES (LED_HOLD_CYCLES)
  ) u_rx_stretch (
    .pclk       (pclk),
    .presetn    (presetn),
    .byte_pulse (rx_byte),
    .active     (rx_active)
  );

  // 12 MHz output for an attached controller
  clock_out_gen #(
    .STEP (`CLK12_STEP)
  ) u_clk12 (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_out (clk_12m)
  );

  // 6 MHz output
  clock_out_gen #(
    .STEP (`CLK6_STEP)
  ) u_clk6 (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_out (clk_6m)
  );

  // Zero wait state; only unmapped addresses fail
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);

  // Register writes and read data capture
  always_comb begin
    next_pin_func    = pin_func;
    next_wake_enable = wake_enable;
    next_prdata      = prdata;
    // Writes land at the access edge
    if (psel && penable && pwrite) begin
      if (paddr == `PIN_FUNC_OFFSET) begin
        next_pin_func = pwdata[`FUNC_FIELD_WIDTH-1:0];   // [RULE3]
      end else if (paddr == `WAKE_CTRL_OFFSET) begin
        next_wake_enable = pwdata[`WAKE_ENABLE_BIT];
      end
    end
    // Read data is sampled in the setup cycle so it comes from a flop
    if (psel && !penable && !pwrite) begin
      next_prdata = 32'h0000_0000;
      if (paddr == `PIN_FUNC_OFFSET) begin
        next_prdata[`FUNC_FIELD_WIDTH-1:0] = pin_func;
      end else if (paddr == `PIN_STATUS_OFFSET) begin
        next_prdata[`STAT_DRIVE_LSB +: `PIN_COUNT] = config_pin_out;
        next_prdata[`STAT_OE_LSB +: `PIN_COUNT]    = config_pin_oe;
        next_prdata[`STAT_SUSPEND_BIT]             = usb_suspended;
        next_prdata[`STAT_SHIFT_BIT]               = tx_shifting;
        next_prdata[`STAT_TX_ACT_BIT]              = tx_active;
        next_prdata[`STAT_RX_ACT_BIT]              = rx_active;
      end else if (paddr == `WAKE_CTRL_OFFSET) begin
        next_prdata[`WAKE_ENABLE_BIT] = wake_enable;
      end else begin
        // Unmapped reads return zero alongside the error
        next_prdata = 32'h0000_0000;
      end
    end
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_func    <= `PIN_FUNC_RESET;                    // [RULE2]
      wake_enable <= `WAKE_CTRL_RESET;
      prdata      <= 32'h0000_0000;
    end else begin
      pin_func    <= next_pin_func;
      wake_enable <= next_wake_enable;
      prdata      <= next_prdata;
    end
  end

  // Per-pin drive from the selected function
  always_comb begin
    pin_drive_type d;
    d            = '{oe: 1'b0, level: 1'b0};
    next_pin_out = 5'h00;
    next_pin_oe  = 5'h00;
    for (int i = 0; i < `PIN_COUNT; i++) begin
      d               = pin_drive(pin_func[i*`FUNC_WIDTH +: `FUNC_WIDTH]);
      next_pin_out[i] = d.level;
      next_pin_oe[i]  = d.oe;
    end
  end

  // Pin drive flops; released during reset so nothing is driven early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_pin_out <= 5'h00;
      config_pin_oe  <= 5'h00;
    end else begin
      config_pin_out <= next_pin_out;
      config_pin_oe  <= next_pin_oe;
    end
  end

  // Wake request on a falling ring level, only while suspended
  always_comb begin
    next_remote_wakeup = wake_enable && usb_suspended &&
                         ring_prev && !ring_indicator_n;   // [RULE9]
  end

  // Ring edge history and one-cycle wake pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_prev     <= 1'b1;
      remote_wakeup <= 1'b0;
    end else begin
      ring_prev     <= ring_indicator_n;
      remote_wakeup <= next_remote_wakeup;
    end
  end

  // Pin inputs are not used by any output function yet
  logic unused_pin_in;
  assign unused_pin_in = ^config_pin_in;

endmodule // config_pin_status_outputs
`default_nettype wire

/* File: sim/config_pin_status_outputs_monitor.sv */
// Purpose: Port checks for the configurable status pins.
// Assumes: Pin functions and wake enable shadowed from APB writes.
// Notes:   Pins lag their status inputs by one pclk and byte pulses by two.
`timescale 1ns/10ps
`default_nettype none
module pin_status_monitor #(
  parameter int unsigned LED_HOLD_CYCLES = 8
) (
  // Clock, reset, APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // Status and pins
  input wire logic        tx_shifting,
  input wire logic        tx_byte,
  input wire logic        rx_byte,
  input wire logic        usb_suspended,
  input wire logic        ring_indicator_n,
  input wire logic        remote_wakeup,
  input wire logic [4:0]  config_pin_out,
  input wire logic [4:0]  config_pin_oe
);
  logic [19:0] fn;  // Shadow of pin functions
  logic        wen; // Shadow of wake enable
  // Shadow updates at the same edge the block takes a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fn  <= 20'h54310;
      wen <= 1'h1;
    end else if (psel && penable && pwrite && paddr == 8'h00) begin
      fn <= pwdata[19:0];
    end else if (psel && penable && pwrite && paddr == 8'h08) begin
      wen <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_drv; $past(presetn) && $past(fn[11:8]) == 4'h3 |->
    config_pin_oe[2] && config_pin_out[2] == $past(tx_shifting); endproperty
  a_drv: assert property (p_drv) else $error("line driver level off");
  property p_pwr; $past(presetn) && $past(fn[15:12]) == 4'h4 |->
    config_pin_oe[3] && config_pin_out[3] == $past(usb_suspended); endproperty
  a_pwr: assert property (p_pwr) else $error("power enable level off");
  property p_slp; $past(presetn) && $past(fn[19:16]) == 4'h5 |->
    config_pin_out[4] == !$past(usb_suspended); endproperty
  a_slp: assert property (p_slp) else $error("suspend pin level off");
  property p_led_low; config_pin_oe[0] && $past(fn[3:0]) <= 4'h2 |-> !config_pin_out[0];
  endproperty
  a_led_low: assert property (p_led_low) else $error("lit LED not low");
  property p_led_on; tx_byte && fn[3:0] == 4'h0 ##1 fn[3:0] == 4'h0 |-> ##1 config_pin_oe[0];
  endproperty
  a_led_on: assert property (p_led_on) else $error("tx LED not lit");
  property p_cmb; rx_byte && fn[11:8] == 4'h2 ##1 fn[11:8] == 4'h2 |-> ##1 config_pin_oe[2];
  endproperty
  a_cmb: assert property (p_cmb) else $error("combined LED not lit");
  property p_hold; $rose(config_pin_oe[0]) && fn[3:0] == 4'h0 |-> config_pin_oe[0] [*7];
  endproperty
  a_hold: assert property (p_hold) else $error("LED pulse too short");
  property p_off; (!tx_byte && !rx_byte) [*8] ##1 (!tx_byte && !rx_byte) [*4] ##0
    $past(fn[3:0]) <= 4'h2 |-> !config_pin_oe[0]; endproperty
  a_off: assert property (p_off) else $error("LED not released");
  property p_wake; usb_suspended && wen && $fell(ring_indicator_n) |=> remote_wakeup;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not requested");
  property p_wake_src; remote_wakeup |-> $past(usb_suspended) && !$past(ring_indicator_n)
    && $past(ring_indicator_n, 2); endproperty
  a_wake_src: assert property (p_wake_src) else $error("wake without cause");
endmodule // pin_status_monitor
bind config_pin_status_outputs pin_status_monitor #(.LED_HOLD_CYCLES(LED_HOLD_CYCLES)) mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .tx_shifting(tx_shifting), .tx_byte(tx_byte),
  .rx_byte(rx_byte), .usb_suspended(usb_suspended), .ring_indicator_n(ring_indicator_n),
  .remote_wakeup(remote_wakeup), .config_pin_out(config_pin_out),
  .config_pin_oe(config_pin_oe));
`default_nettype wire

/* File: sim/config_pin_status_outputs_tb_top.sv */
// Purpose: Self-checking bench for the configurable status pins.
// Assumes: Hold time shortened to 8 cycles.
// Notes:   Static functions run from a table, timed cases by hand.
`timescale 1ns/10ps
`default_nettype none
module config_pin_status_outputs_tb_top;
  import cfg_pin_pkg::*;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, remote_wakeup, ring_indicator_n, ring_req = 1'h0;
  logic        tx_shifting = 1'h0, tx_byte = 1'h0, rx_byte = 1'h0, usb_suspended = 1'h0;
  logic [4:0]  pin_out, pin_oe, pin_level;
  int          n_mismatch = 0, n_checks = 0, n;
  logic [4:0]  pin_out_s, pin_oe_s, pin_level_s;  // Pin values settled mid-cycle
  logic        wake_s, prev;                      // Settled wake pulse, last clock level
  // Function word, shifting, suspended, expected level and enable
  typedef struct packed {
    logic [19:0] fn; logic sh; logic su; logic [4:0] out; logic [4:0] oe;
  } row_type;
  row_type rows [9] = '{'{20'h33333, 1'h1, 1'h0, 5'h1F, 5'h1F},
    '{20'h33333, 1'h0, 1'h0, 5'h00, 5'h1F}, '{20'h44444, 1'h0, 1'h0, 5'h00, 5'h1F},
    '{20'h44444, 1'h0, 1'h1, 5'h1F, 5'h1F}, '{20'h55555, 1'h0, 1'h0, 5'h1F, 5'h1F},
    '{20'h55555, 1'h0, 1'h1, 5'h00, 5'h1F}, '{20'h88888, 1'h0, 1'h0, 5'h00, 5'h00},
    '{20'hFFFFF, 1'h0, 1'h0, 5'h00, 5'h00}, '{20'h00000, 1'h0, 1'h0, 5'h00, 5'h00}};
  always #12.5 pclk = ~pclk;
  // Outputs are looked at on the falling edge, well away from their launch edge
  always @(negedge pclk) begin
    pin_out_s   <= pin_out;
    pin_oe_s    <= pin_oe;
    pin_level_s <= pin_level;
    wake_s      <= remote_wakeup;
  end
  config_pin_status_outputs #(.LED_HOLD_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_shifting(tx_shifting),
    .tx_byte(tx_byte), .rx_byte(rx_byte), .usb_suspended(usb_suspended),
    .ring_indicator_n(ring_indicator_n), .remote_wakeup(remote_wakeup),
    .config_pin_in(pin_level), .config_pin_out(pin_out), .config_pin_oe(pin_oe));
  pin_far_side far_u (.pin_out(pin_out), .pin_oe(pin_oe), .ring_req(ring_req),
    .pin_level(pin_level), .ring_indicator_n(ring_indicator_n));
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // One APB transfer; waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    cyc(1);
    penable <= 1'h1;
    do begin cyc(1); k++; end while (pready !== 1'h1 && k < 50);
    if (k >= 50) n_mismatch++;
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // One idle cycle so a following call never reassigns psel in this step
    cyc(1);
  endtask
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pulse(input logic rx);
    if (rx) rx_byte <= 1'h1; else tx_byte <= 1'h1;
    cyc(1);
    rx_byte <= 1'h0;
    tx_byte <= 1'h0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    #(25 * 30000);
    n_mismatch++;
    conclude;
  end
  initial begin
    cyc(8);
    presetn <= 1'h1;
    cyc(1);
    foreach (rows[i]) begin
      apb(1'h1, 8'h00, {12'h000, rows[i].fn});
      tx_shifting <= rows[i].sh;
      usb_suspended <= rows[i].su;
      cyc(3);
      chk("oe", 20'(pin_oe_s), 20'(rows[i].oe));
      chk("out", 20'(pin_out_s & pin_oe_s), 20'(rows[i].out));
    end
    // Mid-run reset restores default functions
    presetn <= 1'h0;
    cyc(2);
    presetn <= 1'h1;
    cyc(3);
    chk("dflt_oe", 20'(pin_oe_s[4:2]), 20'h7);
    chk("dflt_out", 20'(pin_out_s[4:2]), 20'h4);
    apb(1'h0, 8'h00, 32'h0);
    chk("func", q[19:0], 20'h54310);
    // Status word: pin levels, enables, idle flags
    apb(1'h0, 8'h04, 32'h0);
    chk("status", q[19:0], 20'h00390);
    apb(1'h0, 8'h08, 32'h0);
    chk("wake_en", q[19:0], 20'h00001);
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped", 20'(e), 20'h1);
    // LEDs: pin0 tx, pin1 rx, pin2 combined, pins 3-4 tx
    apb(1'h1, 8'h00, 32'h00210);
    pulse(1'h0);
    cyc(3);
    chk("tx_led", 20'(pin_level_s), 20'h02);
    cyc(12);
    chk("idle", 20'(pin_level_s), 20'h1F);
    pulse(1'h1);
    cyc(3);
    chk("rx_led", 20'(pin_level_s), 20'h19);
    cyc(12);
    // Second byte must restart the hold
    pulse(1'h0);
    cyc(5);
    pulse(1'h0);
    cyc(7);
    chk("retrig", 20'(pin_level_s[0]), 20'h0);
    // Clock outputs: 12 and 6 MHz rise counts over 200 cycles
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, 8'h00, {12'h000, {5{4'(6 + i)}}});
      cyc(4);
      n = 0;
      prev = pin_out_s[0];
      repeat (200) begin
        cyc(1);
        if (pin_out_s[0] === 1'h1 && prev === 1'h0) n++;
        prev = pin_out_s[0];
      end
      chk("clk_rate", 20'(n >= (60 >> i) - 1 && n <= (60 >> i) + 1), 20'h1);
    end
    // Wake: suspended and enabled, then not suspended, then disabled
    for (int i = 0; i < 3; i++) begin
      usb_suspended <= (i != 1);
      apb(1'h1, 8'h08, {31'h0, i != 2});
      ring_req <= 1'h1;
      n = 0;
      repeat (6) begin
        cyc(1);
        if (wake_s === 1'h1) n++;
      end
      ring_req <= 1'h0;
      cyc(2);
      chk("wake", 20'(n), 20'(i == 0));
    end
    conclude;
  end
endmodule // config_pin_status_outputs_tb_top
`default_nettype wire

/* File: sim/pin_far_side.sv */
// Purpose: Board side of the five status pins: LEDs, pull-ups, controller.
// Assumes: A released pin floats high through its LED or pull-up.
// Notes:   Ring line is driven low only while the bench asks for it.
`timescale 1ns/10ps
`default_nettype none
module pin_far_side (
  // Design side
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  // Controller request
  input  wire logic       ring_req,
  // Board side
  output logic [4:0]      pin_level,
  output logic            ring_indicator_n
);
  // Undriven pins read high, never the last driven level
  assign pin_level = (pin_oe & pin_out) | ~pin_oe;
  // Controller pulls the ring line low to ask for a wake
  assign ring_indicator_n = !ring_req;
endmodule // pin_far_side
`default_nettype wire
